/* File: hdl/sfa_regs.vh */
// Purpose: Shared constants of the fixed-point speech arithmetic unit
// Assumes: Included by bare name from every design file
// Notes: Definitions only, no logic
`ifndef SFA_REGS_VH
`define SFA_REGS_VH

// Operation codes
`define SFA_OP_W 5
`define SFA_OP_ADD 5'h00
`define SFA_OP_SUB 5'h01
`define SFA_OP_MULT 5'h02
`define SFA_OP_MULTR 5'h03
`define SFA_OP_ABS 5'h04
`define SFA_OP_DIV 5'h05
`define SFA_OP_LMULT 5'h06
`define SFA_OP_LADD 5'h07
`define SFA_OP_LSUB 5'h08
`define SFA_OP_NORM 5'h09
`define SFA_OP_SHL 5'h0A
`define SFA_OP_SHR 5'h0B
`define SFA_OP_LSHL 5'h0C
`define SFA_OP_LSHR 5'h0D
`define SFA_OP_WIDEN 5'h0E
`define SFA_OP_NARROW 5'h0F
`define SFA_OP_SMASK 5'h10
`define SFA_OP_PMASK 5'h11

// Saturation limits and arithmetic constants
`define SFA_MAX16 16'h7FFF
`define SFA_MIN16 16'h8000
`define SFA_MAX32 32'h7FFFFFFF
`define SFA_MIN32 32'h80000000
`define SFA_ROUND32 32'h00004000
`define SFA_NORM_EDGE 32'hC0000000
`define SFA_MULT_SHIFT 15
`define SFA_DIV_ITER 15

// Valid-bit masks on received words
`define SFA_SAMPLE_MASK 16'hFFF8
`define SFA_PW_MIN 4'h2
`define SFA_PW_MAX 4'h7

// Frame structure
`define SFA_FRAME_LAST 8'h9F
`define SFA_SEG_LAST 6'h27
`define SFA_LAR_LAST 4'h7
`define SFA_SUB_LAST 5'h10
`define SFA_PULSE_BASE 5'h04

// Parameter kinds announced by the slot sequencer
`define SFA_K_AREA 3'h0
`define SFA_K_LAG 3'h1
`define SFA_K_GAIN 3'h2
`define SFA_K_GRID 3'h3
`define SFA_K_PEAK 3'h4
`define SFA_K_PULSE 3'h5

`endif

/* File: hdl/sfa_div.v */
// Purpose: Restoring fractional divider, fifteen quotient bits
// Assumes: Caller gives 0 < num <= den with start; both are loaded then
// Notes: Start reloads even while busy; done is a one-cycle pulse
`include "sfa_regs.vh"
`default_nettype none

module sfa_div #(
  parameter ITER = `SFA_DIV_ITER
) (
  // Clock and reset
  input wire clk,
  input wire rst_b,
  // Request
  input wire start,
  input wire [15:0] num,
  input wire [15:0] den,
  // Answer
  output reg done,
  output reg [15:0] quo
);

  // Last step index, cut to the counter width on purpose
  localparam integer ITER_I = ITER - 1;
  localparam [3:0] ITER_M1 = ITER_I[3:0];

  reg [31:0] num_q;
  reg [31:0] den_q;
  reg [3:0] cnt_q;
  reg run_q;
  wire [31:0] shifted;
  wire take;

  // Numerator doubled each step before the trial subtraction
  assign shifted = {num_q[30:0], 1'b0};
  assign take = (shifted >= den_q);

  // One quotient bit per clock
  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      num_q <= 32'h00000000;
      den_q <= 32'h00000000;
      cnt_q <= 4'h0;
      run_q <= 1'b0;
      done <= 1'b0;
      quo <= 16'h0000;
    end
    else if (start)
    begin
      num_q <= {16'h0000, num};
      den_q <= {16'h0000, den};
      quo <= 16'h0000;
      cnt_q <= 4'h0;
      run_q <= 1'b1;
      done <= 1'b0;
    end
    else if (run_q)
    begin
      // RL21: restoring iteration step
      if (take)
      begin
        num_q <= shifted - den_q;
        quo <= {quo[14:0], 1'b1};
      end
      else
      begin
        num_q <= shifted;
        quo <= {quo[14:0], 1'b0};
      end
      cnt_q <= cnt_q + 4'h1;
      if (cnt_q == ITER_M1)
      begin
        run_q <= 1'b0;
        done <= 1'b1;
      end
    end
    else
    begin
      done <= 1'b0;
    end
  end

endmodule // sfa_div

`default_nettype wire

/* File: hdl/sfa_alu.v */
// Purpose: Saturating 16/32-bit fixed-point unit for a speech coder
// Assumes: One clock; callers are logic on the same clock
// Notes: Word results come back sign-extended to 32 bits
// Contract
// RL1: Only signed 16-bit words and signed 32-bit long words are handled.
// RL2: Word sum saturates to +32767 and -32768.
// RL3: Word difference a minus b saturates to +32767 and -32768.
// RL4: Scaled product is product shifted right 15; min times min is 32767.
// RL5: Rounded product adds 16384 before shifting; min times min is 32767.
// RL6: Magnitude of a word; -32768 gives 32767.
// RL7: Quotient needs 0 < num <= den; truncated 16 bits, equal gives 32767.
// RL8: Long product is word product shifted left one; min times min never.
// RL9: Long sum saturates to 2147483647 and -2147483648.
// RL10: Long difference saturates to 2147483647 and -2147483648.
// RL11: Norm counts left shifts bringing a long into its normal range.
// RL12: Left shift zero-fills; negative count shifts right arithmetically.
// RL13: Right shift sign-extends; negative count shifts left zero-filled.
// RL14: Widening puts the word low and sign-extends the upper half.
// RL15: Narrowing keeps the low 16 bits without saturation.
// RL16: Constants in long operations are sign-extended to 32 bits first.
// RL17: Received words keep only valid bits; sample LSBs, parameter MSBs drop.
// RL18: Frames hold 160 samples in four 40-sample sub-segments.
// RL19: Once per frame eight coded area ratios follow the full frame.
// RL20: Each sub-segment yields lag, gain, grid, peak and thirteen pulses.
// RL21: Quotient uses a fifteen-step restoring divider.
// RL22: Every result arrives a fixed number of cycles after acceptance.
`include "sfa_regs.vh"
`default_nettype none

module sfa_alu (
  // Clock and reset
  input wire clk,
  input wire rst_b,
  // Operation request
  input wire op_valid,
  input wire [4:0] op_code,
  input wire [31:0] op_a,
  input wire [31:0] op_b,
  output reg op_ready,
  // Result
  output reg res_valid,
  output reg [31:0] res_data,
  output reg res_sat,
  output reg div_bad,
  // Frame timing
  input wire sample_tick,
  input wire frame_restart,
  output reg [7:0] sample_idx,
  output reg [1:0] subseg_idx,
  output reg subseg_done,
  output reg frame_done,
  // Parameter slot announcements
  output reg param_strobe,
  output reg [2:0] param_kind,
  output reg [3:0] param_index
);

  localparam [1:0] SEQ_IDLE = 2'h0;
  localparam [1:0] SEQ_SUB = 2'h1;
  localparam [1:0] SEQ_FRM = 2'h2;

  // RL1: operands seen as words or long words
  wire [15:0] a16 = op_a[15:0];
  wire [15:0] b16 = op_b[15:0];
  wire accept = op_valid & op_ready;
  wire is_div = (op_code == `SFA_OP_DIV);
  wire div_done;
  wire [15:0] div_quo;

  reg [31:0] res_d;
  reg sat_d;
  reg div_eq_q;
  reg div_bad_q;
  reg [5:0] seg_cnt_q;
  reg [1:0] seq_q;
  reg [4:0] slot_q;
  reg frm_pend_q;

  // Widened sums keep the carry for overflow detection
  wire [16:0] sum17 = {a16[15], a16} + {b16[15], b16};
  wire [16:0] dif17 = {a16[15], a16} - {b16[15], b16};
  wire [32:0] lsum = {op_a[31], op_a} + {op_b[31], op_b};
  wire [32:0] ldif = {op_a[31], op_a} - {op_b[31], op_b};
  wire signed [31:0] prod = $signed(a16) * $signed(b16);
  // RL16: rounding constant held at full 32-bit width
  wire [31:0] prod_r = prod + `SFA_ROUND32;
  wire both_min = (a16 == `SFA_MIN16) && (b16 == `SFA_MIN16);
  wire [15:0] neg16 = 16'h0000 - a16;
  // Pulse number from slot position; slot 16 gives pulse 12, which fits in four bits
  wire [4:0] pulse_idx = slot_q - `SFA_PULSE_BASE;
  wire [15:0] pw = (b16[3:0] < `SFA_PW_MIN) ? {12'h000, `SFA_PW_MIN} :
                   (b16[3:0] > `SFA_PW_MAX) ? {12'h000, `SFA_PW_MAX} :
                   {12'h000, b16[3:0]};
  wire [15:0] pmask = ~(16'hFFFF << pw[3:0]);

  // Signed shift by a signed count; out-of-range counts clamp
  function [31:0] sfa_shift;
    input [31:0] v;
    input [15:0] n;
    input go_left;
    reg [15:0] m;
    reg left;
    reg [5:0] amt;
    begin
      m = n[15] ? (16'h0000 - n) : n;
      left = go_left ^ n[15];
      amt = (m > 16'h0020) ? 6'h20 : m[5:0];
      // Right shift kept apart: an unsigned branch would kill sign fill
      if (left)
        sfa_shift = (amt[5]) ? 32'h00000000 : (v << amt);
      else if (amt[5])
        sfa_shift = {32{v[31]}};
      else
        sfa_shift = $signed(v) >>> amt;
    end
  endfunction

  // Count of redundant sign bits; zero input gives zero
  function [4:0] sfa_norm;
    input [31:0] v;
    integer i;
    reg stop;
    reg [4:0] cnt;
    begin
      cnt = 5'h00;
      stop = 1'b0;
      for (i = 30; i >= 0; i = i - 1)
      begin
        if (!stop && (v[i] == v[31]))
          cnt = cnt + 5'h01;
        else
          stop = 1'b1;
      end
      // Upper bound of the negative range is already normal
      if ((v == 32'h00000000) || (v == `SFA_NORM_EDGE))
        sfa_norm = 5'h00;
      else
        sfa_norm = cnt;
    end
  endfunction

  // Result of every single-cycle operation
  always @*
  begin
    res_d = 32'h00000000;
    sat_d = 1'b0;
    case (op_code)
      `SFA_OP_ADD:
      begin
        // RL2: clamp word sum
        sat_d = sum17[16] ^ sum17[15];
        res_d = {{16{sum17[16]}}, sum17[15:0]};
        if (sat_d)
          res_d = sum17[16] ? {16'hFFFF, `SFA_MIN16} :
                  {16'h0000, `SFA_MAX16};
      end
      `SFA_OP_SUB:
      begin
        // RL3: clamp word difference
        sat_d = dif17[16] ^ dif17[15];
        res_d = {{16{dif17[16]}}, dif17[15:0]};
        if (sat_d)
          res_d = dif17[16] ? {16'hFFFF, `SFA_MIN16} :
                  {16'h0000, `SFA_MAX16};
      end
      `SFA_OP_MULT:
      begin
        // RL4: scaled product with corner
        sat_d = both_min;
        res_d = both_min ? {16'h0000, `SFA_MAX16} :
                {{16{prod[30]}}, prod[30:15]};
      end
      `SFA_OP_MULTR:
      begin
        // RL5: rounded scaled product
        sat_d = both_min;
        res_d = both_min ? {16'h0000, `SFA_MAX16} :
                {{16{prod_r[30]}}, prod_r[30:15]};
      end
      `SFA_OP_ABS:
      begin
        // RL6: magnitude with saturation
        sat_d = (a16 == `SFA_MIN16);
        if (sat_d)
          res_d = {16'h0000, `SFA_MAX16};
        else if (a16[15])
          res_d = {16'h0000, neg16};
        else
          res_d = {16'h0000, a16};
      end
      `SFA_OP_LMULT:
      begin
        // RL8: doubled long product
        sat_d = both_min;
        res_d = both_min ? `SFA_MAX32 : {prod[30:0], 1'b0};
      end
      `SFA_OP_LADD:
      begin
        // RL9: clamp long sum
        sat_d = lsum[32] ^ lsum[31];
        res_d = sat_d ? (lsum[32] ? `SFA_MIN32 : `SFA_MAX32) :
                lsum[31:0];
      end
      `SFA_OP_LSUB:
      begin
        // RL10: clamp long difference
        sat_d = ldif[32] ^ ldif[31];
        res_d = sat_d ? (ldif[32] ? `SFA_MIN32 : `SFA_MAX32) :
                ldif[31:0];
      end
      `SFA_OP_NORM:
      begin
        // RL11: normalisation shift count
        res_d = {27'h0, sfa_norm(op_a)};
      end
      `SFA_OP_SHL:
      begin
        // RL12: word left shift
        res_d = sfa_shift({{16{a16[15]}}, a16}, b16, 1'b1);
        res_d = {{16{res_d[15]}}, res_d[15:0]};
      end
      `SFA_OP_SHR:
      begin
        // RL13: word right shift
        res_d = sfa_shift({{16{a16[15]}}, a16}, b16, 1'b0);
        res_d = {{16{res_d[15]}}, res_d[15:0]};
      end
      `SFA_OP_LSHL:
      begin
        // RL12: long left shift
        res_d = sfa_shift(op_a, b16, 1'b1);
      end
      `SFA_OP_LSHR:
      begin
        // RL13: long right shift
        res_d = sfa_shift(op_a, b16, 1'b0);
      end
      `SFA_OP_WIDEN:
      begin
        // RL14: sign-extending deposit
        res_d = {{16{a16[15]}}, a16};
      end
      `SFA_OP_NARROW:
      begin
        // RL15: low half, no saturation
        res_d = {{16{op_a[15]}}, op_a[15:0]};
      end
      `SFA_OP_SMASK:
      begin
        // RL17: drop invalid sample LSBs
        res_d = {{16{a16[15]}}, a16 & `SFA_SAMPLE_MASK};
      end
      `SFA_OP_PMASK:
      begin
        // RL17: drop invalid parameter MSBs
        res_d = {16'h0000, a16 & pmask};
      end
      default:
      begin
        res_d = 32'h00000000;
        sat_d = 1'b0;
      end
    endcase
  end

  // RL21: divider runs the quotient
  sfa_div #(
    .ITER(`SFA_DIV_ITER)
  ) u_div (
    .clk(clk),
    .rst_b(rst_b),
    .start(accept & is_div),
    .num(a16),
    .den(b16),
    .done(div_done),
    .quo(div_quo)
  );

  // Result register; divide holds off new requests until done
  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      op_ready <= 1'b1;
      res_valid <= 1'b0;
      res_data <= 32'h00000000;
      res_sat <= 1'b0;
      div_bad <= 1'b0;
      div_eq_q <= 1'b0;
      div_bad_q <= 1'b0;
    end
    else if (accept && is_div)
    begin
      // RL7: operand check, equality shortcut
      op_ready <= 1'b0;
      res_valid <= 1'b0;
      div_eq_q <= (a16 == b16);
      div_bad_q <= a16[15] || (a16 == 16'h0000) || b16[15] ||
                   (b16 < a16);
    end
    else if (accept)
    begin
      // RL22: one-cycle fixed latency
      res_valid <= 1'b1;
      res_data <= res_d;
      res_sat <= sat_d;
      div_bad <= 1'b0;
    end
    else if (div_done)
    begin
      // RL22: divide latency fixed at seventeen
      op_ready <= 1'b1;
      res_valid <= 1'b1;
      res_data <= div_eq_q ? {16'h0000, `SFA_MAX16} :
                  {16'h0000, div_quo};
      res_sat <= 1'b0;
      div_bad <= div_bad_q;
    end
    else
    begin
      res_valid <= 1'b0;
    end
  end

  // Sample position inside the frame and sub-segment
  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      sample_idx <= 8'h00;
      seg_cnt_q <= 6'h00;
      subseg_idx <= 2'h0;
      subseg_done <= 1'b0;
      frame_done <= 1'b0;
    end
    else if (frame_restart)
    begin
      sample_idx <= 8'h00;
      seg_cnt_q <= 6'h00;
      subseg_idx <= 2'h0;
      subseg_done <= 1'b0;
      frame_done <= 1'b0;
    end
    else if (sample_tick)
    begin
      // RL18: 160-sample frame, 40-sample segments
      subseg_done <= (seg_cnt_q == `SFA_SEG_LAST);
      frame_done <= (sample_idx == `SFA_FRAME_LAST);
      if (sample_idx == `SFA_FRAME_LAST)
        sample_idx <= 8'h00;
      else
        sample_idx <= sample_idx + 8'h01;
      if (seg_cnt_q == `SFA_SEG_LAST)
      begin
        seg_cnt_q <= 6'h00;
        subseg_idx <= subseg_idx + 2'h1;
      end
      else
        seg_cnt_q <= seg_cnt_q + 6'h01;
    end
    else
    begin
      subseg_done <= 1'b0;
      frame_done <= 1'b0;
    end
  end

  // Slot sequencer; a segment lasts 40 ticks, longer than 25 slots,
  // so a new segment never lands on a running announcement
  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      seq_q <= SEQ_IDLE;
      slot_q <= 5'h00;
      frm_pend_q <= 1'b0;
      param_strobe <= 1'b0;
      param_kind <= `SFA_K_AREA;
      param_index <= 4'h0;
    end
    else if (frame_restart)
    begin
      seq_q <= SEQ_IDLE;
      slot_q <= 5'h00;
      frm_pend_q <= 1'b0;
      param_strobe <= 1'b0;
    end
    else
    begin
      case (seq_q)
        SEQ_IDLE:
        begin
          param_strobe <= 1'b0;
          slot_q <= 5'h00;
          if (subseg_done)
          begin
            seq_q <= SEQ_SUB;
            frm_pend_q <= frame_done;
          end
        end
        SEQ_SUB:
        begin
          // RL20: per-segment code slots
          param_strobe <= 1'b1;
          param_index <= 4'h0;
          case (slot_q)
            5'h00: param_kind <= `SFA_K_LAG;
            5'h01: param_kind <= `SFA_K_GAIN;
            5'h02: param_kind <= `SFA_K_GRID;
            5'h03: param_kind <= `SFA_K_PEAK;
            default:
            begin
              param_kind <= `SFA_K_PULSE;
              param_index <= pulse_idx[3:0];
            end
          endcase
          if (slot_q == `SFA_SUB_LAST)
          begin
            slot_q <= 5'h00;
            seq_q <= frm_pend_q ? SEQ_FRM : SEQ_IDLE;
          end
          else
            slot_q <= slot_q + 5'h01;
        end
        SEQ_FRM:
        begin
          // RL19: eight area ratios per frame
          param_strobe <= 1'b1;
          param_kind <= `SFA_K_AREA;
          param_index <= slot_q[3:0];
          frm_pend_q <= 1'b0;
          if (slot_q[3:0] == `SFA_LAR_LAST)
          begin
            slot_q <= 5'h00;
            seq_q <= SEQ_IDLE;
          end
          else
            slot_q <= slot_q + 5'h01;
        end
        default:
        begin
          seq_q <= SEQ_IDLE;
          param_strobe <= 1'b0;
        end
      endcase
    end
  end

endmodule // sfa_alu

`default_nettype wire

/* File: test/sfa_alu_checker.sv */
// Purpose: Port checks on the fixed-point arithmetic unit
// Assumes: Bound to sfa_alu; one clock domain
// Notes: Word results are compared sign-extended to 32 bits
`include "sfa_regs.vh"
`default_nettype none

module sfa_alu_checker (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Operations
  input wire logic op_valid,
  input wire logic [4:0] op_code,
  input wire logic [31:0] op_a,
  input wire logic [31:0] op_b,
  input wire logic op_ready,
  input wire logic res_valid,
  input wire logic [31:0] res_data,
  input wire logic res_sat,
  // Frame and slots
  input wire logic subseg_done,
  input wire logic frame_done,
  input wire logic [7:0] sample_idx,
  input wire logic [1:0] subseg_idx,
  input wire logic param_strobe,
  input wire logic [2:0] param_kind
);
  timeunit 1ns;
  timeprecision 1ns;
  logic acc;
  logic [16:0] s17;

  // Accepted request; word sum one bit wider to see overflow
  assign acc = op_valid && op_ready;
  assign s17 = {op_a[15], op_a[15:0]} + {op_b[15], op_b[15:0]};

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  ans_next_a: assert property (
    acc && op_code != `SFA_OP_DIV |=> res_valid)
    else $error("No result one cycle after accept");
  div_lat_a: assert property (
    acc && op_code == `SFA_OP_DIV
    |=> (!op_ready)[*8] ##1 (!op_ready)[*8] ##1 (res_valid && op_ready))
    else $error("Quotient not on its fixed cycle");
  add_hi_a: assert property (
    acc && op_code == `SFA_OP_ADD && s17[16:15] == 2'b01
    |=> res_data == 32'h00007FFF && res_sat)
    else $error("Word sum not clamped high");
  add_lo_a: assert property (
    acc && op_code == `SFA_OP_ADD && s17[16:15] == 2'b10
    |=> res_data == 32'hFFFF8000 && res_sat)
    else $error("Word sum not clamped low");
  mult_min_a: assert property (
    acc && (op_code == `SFA_OP_MULT || op_code == `SFA_OP_MULTR)
    && op_a[15:0] == 16'h8000 && op_b[15:0] == 16'h8000
    |=> res_data == 32'h00007FFF)
    else $error("Scaled product of minimums wrong");
  abs_min_a: assert property (
    acc && op_code == `SFA_OP_ABS && op_a[15:0] == 16'h8000
    |=> res_data == 32'h00007FFF)
    else $error("Magnitude of minimum wrong");
  ext_word_a: assert property (
    acc && (op_code == `SFA_OP_WIDEN || op_code == `SFA_OP_NARROW)
    |=> res_data == {{16{$past(op_a[15])}}, $past(op_a[15:0])})
    else $error("Widen or narrow result wrong");
  frame_end_a: assert property (
    frame_done |-> subseg_done && sample_idx == 8'h00
    && subseg_idx == 2'h0)
    else $error("Frame end not aligned with segment");
  slot_start_a: assert property (
    subseg_done |-> ##2 param_strobe && param_kind == 3'h1)
    else $error("Segment slots did not start with lag");

  // Main scenarios reached
  div_c: cover property (acc && op_code == `SFA_OP_DIV);
  frame_c: cover property (frame_done);
  area_c: cover property (param_strobe && param_kind == 3'h0);
endmodule // sfa_alu_checker
`default_nettype wire

/* File: test/sfa_caller.sv */
// Purpose: Model of the coder stage that issues operations
// Assumes: Same clock as the unit; drives at the falling edge
// Notes: Released operand lines show the inverse of the last value
`default_nettype none

module sfa_caller (
  // Clock
  input wire logic clk,
  // Request
  output logic op_valid,
  output logic [4:0] op_code,
  output logic [31:0] op_a,
  output logic [31:0] op_b,
  input wire logic op_ready,
  // Result
  input wire logic res_valid,
  input wire logic [31:0] res_data
);
  timeunit 1ns;
  timeprecision 1ns;

  // Idle request at time zero
  initial
  begin
    op_valid = 1'b0;
    op_code = 5'h00;
    op_a = 32'h00000000;
    op_b = 32'h00000000;
  end

  // One operation; slow adds idle cycles before the request
  // bench hands only legal quotient and long product operands
  task automatic run(input logic [4:0] c, input logic [31:0] a, b,
    input int slow, output logic [31:0] r);
    int n;
    r = 'x;
    n = 0;
    repeat (slow + 1) @(negedge clk);
    op_valid = 1'b1;
    op_code = c;
    op_a = a;
    op_b = b;
    // Hold until the next edge samples op_ready high
    while (op_ready !== 1'b1 && n < 40)
    begin
      n++;
      @(negedge clk);
    end
    @(negedge clk);
    // Released lines flip so stale operands cannot pass
    op_valid = 1'b0;
    op_a = ~a;
    op_b = ~b;
    while (res_valid !== 1'b1 && n < 60)
    begin
      n++;
      @(negedge clk);
    end
    if (res_valid === 1'b1)
      r = res_data;
  endtask
endmodule // sfa_caller
`default_nettype wire

/* File: test/tb_sfa_alu.sv */
// Purpose: Self-checking bench for the fixed-point arithmetic unit
// Assumes: Caller model issues operations; bench drives frame ticks
// Notes: Expected values worked out by hand from the arithmetic
`default_nettype none

module tb_sfa_alu;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic sample_tick = 1'b0;
  logic frame_restart = 1'b0;
  wire op_valid, op_ready, res_valid, res_sat, div_bad;
  wire [4:0] op_code;
  wire [31:0] op_a, op_b, res_data;
  wire [7:0] sample_idx;
  wire [1:0] subseg_idx;
  wire subseg_done, frame_done, param_strobe;
  wire [2:0] param_kind;
  wire [3:0] param_index;
  int err_count = 0;
  int compares = 0;

  sfa_alu u_sfa_alu (.*);
  sfa_caller u_sfa_caller (.*);

  // 100 MHz clock
  always #5 clk = ~clk;

  task automatic chk(input string nm, input logic [31:0] exp, got);
    compares++;
    if (got !== exp)
    begin
      err_count++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic op(input string nm, input logic [4:0] c,
    input logic [31:0] a, b, e);
    logic [31:0] r;
    u_sfa_caller.run(c, a, b, 0, r);
    chk(nm, e, r);
  endtask

  // Clamps and corner products; only the add hi case gives a word operand junk upper bits
  task automatic t_word();
    op("add hi", 5'h00, 32'hABCD7FFF, 32'h00000001, 32'h00007FFF);
    op("add lo", 5'h00, 32'h00008000, 32'h0000FFFF, 32'hFFFF8000);
    op("sub lo", 5'h01, 32'h00008000, 32'h00000001, 32'hFFFF8000);
    op("sub hi", 5'h01, 32'h00007FFF, 32'h0000FFFF, 32'h00007FFF);
    op("mul min", 5'h02, 32'h00008000, 32'h00008000, 32'h00007FFF);
    op("mul", 5'h02, 32'h00004000, 32'h00004000, 32'h00002000);
    op("mulr min", 5'h03, 32'h00008000, 32'h00008000, 32'h00007FFF);
    op("mulr rnd", 5'h03, 32'h00000001, 32'h00004000, 32'h00000001);
    op("abs min", 5'h04, 32'h00008000, 32'h0, 32'h00007FFF);
    op("abs neg", 5'h04, 32'h0000FFFB, 32'h0, 32'h00000005);
  endtask

  task automatic t_long();
    op("lmul", 5'h06, 32'h00004000, 32'h00004000, 32'h20000000);
    op("lmul neg", 5'h06, 32'h0000FFFF, 32'h00000002, 32'hFFFFFFFC);
    op("ladd hi", 5'h07, 32'h7FFFFFFF, 32'h00000001, 32'h7FFFFFFF);
    op("ladd lo", 5'h07, 32'h80000000, 32'hFFFFFFFF, 32'h80000000);
    op("lsub lo", 5'h08, 32'h80000000, 32'h00000001, 32'h80000000);
    op("lsub hi", 5'h08, 32'h7FFFFFFF, 32'hFFFFFFFF, 32'h7FFFFFFF);
    op("norm 1", 5'h09, 32'h00000001, 32'h0, 32'h0000001E);
    op("norm neg", 5'h09, 32'hC0000000, 32'h0, 32'h00000000);
    op("norm m1", 5'h09, 32'hFFFFFFFF, 32'h0, 32'h0000001F);
  endtask

  task automatic t_shift();
    op("shl", 5'h0A, 32'h00000003, 32'h00000002, 32'h0000000C);
    op("shl neg", 5'h0A, 32'h0000FFF0, 32'h0000FFFE, 32'hFFFFFFFC);
    op("shr", 5'h0B, 32'h00008000, 32'h00000003, 32'hFFFFF000);
    op("shr neg", 5'h0B, 32'h00000001, 32'h0000FFFC, 32'h00000010);
    op("lshl", 5'h0C, 32'h00000001, 32'h0000001F, 32'h80000000);
    op("lshr", 5'h0D, 32'h80000000, 32'h0000001F, 32'hFFFFFFFF);
    op("widen", 5'h0E, 32'h12348001, 32'h0, 32'hFFFF8001);
    op("narrow", 5'h0F, 32'h12348765, 32'h0, 32'hFFFF8765);
  endtask

  // Quotients, then the bad-operand flag after the last divide
  task automatic t_div();
    op("div half", 5'h05, 32'h00000001, 32'h00000002, 32'h00004000);
    op("div 3/4", 5'h05, 32'h00000003, 32'h00000004, 32'h00006000);
    op("div eq", 5'h05, 32'h00000005, 32'h00000005, 32'h00007FFF);
    op("div tiny", 5'h05, 32'h00000001, 32'h00007FFF, 32'h00000001);
    chk("div bad", 32'h0, {31'h0, div_bad});
  endtask

  task automatic t_mask();
    op("smask", 5'h10, 32'h00001237, 32'h0, 32'h00001230);
    op("smask neg", 5'h10, 32'h0000FFFF, 32'h0, 32'hFFFFFFF8);
    op("pmask 3", 5'h11, 32'h0000FFFF, 32'h00000003, 32'h00000007);
    op("pmask lo", 5'h11, 32'h0000FFFF, 32'h00000001, 32'h00000003);
    op("pmask hi", 5'h11, 32'h0000FFFF, 32'h00000009, 32'h0000007F);
  endtask

  // One full frame of ticks every cycle; count pulses and slots
  task automatic t_frame();
    int sd, fd, ps, ar, pi;
    pi = 0;
    sd = 0;
    fd = 0;
    ps = 0;
    ar = 0;
    @(negedge clk);
    frame_restart = 1'b1;
    @(negedge clk);
    frame_restart = 1'b0;
    for (int k = 0; k < 200; k++)
    begin
      @(negedge clk);
      sd += (subseg_done === 1'b1);
      fd += (frame_done === 1'b1);
      ps += (param_strobe === 1'b1);
      ar += (param_strobe === 1'b1 && param_kind === 3'h0);
      pi += (param_strobe === 1'b1) ? int'(param_index) : 0;
      sample_tick = (k < 160);
    end
    chk("segments", 32'h00000004, sd);
    chk("frames", 32'h00000001, fd);
    chk("slot cycles", 32'h0000004C, ps);
    chk("area slots", 32'h00000008, ar);
    // Pulses 0..12 four times plus area ratios 0..7
    chk("slot index sum", 32'h00000154, pi);
    chk("sample idx", 32'h0, {24'h0, sample_idx});
  endtask

  task automatic wrap_up();
    $display("Compares %0d, errors %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // Main sequence after a two-cycle reset
  initial
  begin
    repeat (2) @(negedge clk);
    rst_b = 1'b1;
    t_word();
    t_long();
    t_shift();
    t_div();
    t_mask();
    t_frame();
    wrap_up();
  end

  // Hang guard, about thirty times the expected run
  initial
  begin
    #100000;
    err_count++;
    wrap_up();
  end
endmodule // tb_sfa_alu

bind sfa_alu sfa_alu_checker u_sfa_alu_checker (.*);
`default_nettype wire
